// [hdl/ail_access_interlock.sv]
// Access interlock logic: access states, search, warnings and permissives
`timescale 1ns/1ps

// Summary of operation
// R01: Stopper fault drops up-beam permission during entry
// R02: Tripped permission stays off until operator reset
// R03: Lost security outside permitted access needs new search before reset
// R04: Search preset, progress, complete then warnings
// R05: Lights flash two minutes then dim
// R06: Enables follow door, key and e-off state; keys_all_in feeds only secure, not hazard_perm or beam_perm
// R07: Two in/off signals per stopper for entry
// R08: Violation drops all beam and hazard permissions
// R09: Two permissives per stopper, both dropped
// R10: Burst chamber rupture kills all beams
// R11: Four access states, optional two-state build
// R12: No access allows beam and hazards
// R13: Restricted allows hazards, not beam
// R14: Controlled returns to no access unsearched
// R15: Permitted access needs no new search before enabling
// R16: Key test holds up-beam stoppers inserted
// R17: Key test full lights, key release blocked once team entered
// R18: Two-state secure needs search, closure, timer
// R19: Either chain trip kills beam and hazards
// R20: Remote command needs hardwired enable too
// R21: Momentary trips latch until operator reset
// R22: Unsafe inputs and reset withdraw all permissives
module ail_access_interlock #(
  parameter int N_STOP = 3,
  parameter bit FOUR_STATE = 1'b1,
  parameter longint WARN_CYC = ail_pkg::WARN_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic doors_closed_a,
  input wire logic doors_closed_b,
  input wire logic eoff_ok_a,
  input wire logic eoff_ok_b,
  input wire logic emerg_entry_ok,
  input wire logic keys_all_in,
  input wire logic burst_ok,
  input wire logic [N_STOP-1:0] stop_in_a,
  input wire logic [N_STOP-1:0] stop_in_b,
  input wire logic [N_STOP-1:0] stop_ok,
  input wire logic search_preset_btn,
  input wire logic search_reset_local,
  input wire logic search_reset_ctrl,
  input wire logic intlk_reset_btn,
  input wire logic remote_cmd_valid,
  input wire logic [1:0] remote_cmd_state,
  input wire logic remote_hw_enable,
  input wire logic panel_cmd_valid,
  input wire logic [1:0] panel_cmd_state,
  input wire logic key_test_req,
  input wire logic key_release_req,
  input wire logic latch_release_req,
  input wire logic team_entered,
  input wire logic warn_start,
  output logic [1:0] access_state,
  output logic [1:0] search_step,
  output logic [N_STOP-1:0] stop_perm_a,
  output logic [N_STOP-1:0] stop_perm_b,
  output logic hazard_perm,
  output logic beam_perm,
  output logic key_release,
  output logic latch_release,
  output logic lights_flash,
  output logic lights_dim,
  output logic lights_full,
  output logic audio_warn,
  output logic secure,
  output logic trip_latched,
  output logic search_needed,
  output logic key_test_active
);
  // Shared state, declared ahead of every reader
  logic [1:0] state;
  ail_pkg::ail_search_t search;
  logic kt;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // One flat vector keeps both stages of every input but the command words and remote strobe in step
  localparam int NI = 10 + 3 * N_STOP + 8;
  logic [NI-1:0] raw, s1, s2;
  assign raw = {doors_closed_a, doors_closed_b, eoff_ok_a, eoff_ok_b, emerg_entry_ok, keys_all_in, burst_ok,
                search_preset_btn, search_reset_local, search_reset_ctrl, stop_in_a, stop_in_b, stop_ok,
                intlk_reset_btn, remote_hw_enable, key_test_req, key_release_req, latch_release_req,
                team_entered, warn_start, panel_cmd_valid};

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  wire d_a = s2[NI-1];
  wire d_b = s2[NI-2];
  wire e_a = s2[NI-3];
  wire e_b = s2[NI-4];
  wire emg = s2[NI-5];
  wire keys = s2[NI-6];
  wire bok = s2[NI-7];
  wire sp = s2[NI-8];
  wire srl = s2[NI-9];
  wire src = s2[NI-10];
  wire [N_STOP-1:0] sa = s2[NI-11 -: N_STOP];
  wire [N_STOP-1:0] sb = s2[NI-11-N_STOP -: N_STOP];
  wire [N_STOP-1:0] sk = s2[NI-11-2*N_STOP -: N_STOP];
  wire irst = s2[7];
  wire hwen = s2[6];
  wire ktr = s2[5];
  wire krr = s2[4];
  wire lrr = s2[3];
  wire team = s2[2];
  wire wst = s2[1];
  wire pcv = s2[0];

  // Command words are assumed held stable while the strobe is up
  logic [1:0] rcs1, rcs2, pcs1, pcs2;
  logic rcv1, rcv2;

  always_ff @(posedge clk) begin
    if (srst) begin
      rcs1 <= 2'h0;
      rcs2 <= 2'h0;
      pcs1 <= 2'h0;
      pcs2 <= 2'h0;
      rcv1 <= 1'b0;
      rcv2 <= 1'b0;
    end else begin
      rcs1 <= remote_cmd_state;
      rcs2 <= rcs1;
      pcs1 <= panel_cmd_state;
      pcs2 <= pcs1;
      rcv1 <= remote_cmd_valid;
      rcv2 <= rcv1;
    end
  end

  // ****************************************
  // Chains, trips and violation
  // ****************************************
  // Each chain sees one of the duplicated contacts; low input counts as unsafe
  wire chain_a_ok = d_a & e_a & emg; // see R19 see R22
  wire chain_b_ok = d_b & e_b & emg; // see R19
  wire chains_ok = chain_a_ok & chain_b_ok; // see R19

  wire sec_loss = ~(d_a & d_b) | ~(e_a & e_b) | ~emg; // see R08
  wire stoppers_in = &(sa & sb); // see R07
  // Beam runs with stoppers out, so only damage counts here
  wire stoppers_ok = &sk; // see R01
  // A burst chamber alarm latches like a chain trip
  wire trip_cause = ~chains_ok | ~bok; // see R02 see R10
  logic trip, need_search;
  // Clear only when the fault has gone, so an active trip always wins
  wire reset_ok = irst & ~trip_cause & ~need_search; // see R02 see R03

  always_ff @(posedge clk) begin
    if (srst) begin
      trip <= 1'b1; // see R22
      need_search <= 1'b1;
    end else begin
      if (trip_cause) begin
        trip <= 1'b1; // see R21
      end else if (reset_ok) begin
        trip <= 1'b0; // see R02
      end
      if (sec_loss & (state != ail_pkg::ACC_PERMITTED)) begin
        need_search <= 1'b1; // see R03
      end else if (search == ail_pkg::AIL_S_DONE) begin
        need_search <= 1'b0;
      end
    end
  end

  // ****************************************
  // Access state
  // ****************************************
  wire rem_ok = rcv2 & hwen; // see R20
  wire cmd_v = rem_ok | pcv;
  wire [1:0] cmd_s = pcv ? pcs2 : rcs2;
  wire cmd_legal = FOUR_STATE | (cmd_s == ail_pkg::ACC_NO) | (cmd_s == ail_pkg::ACC_PERMITTED); // see R11
  wire to_entry = (cmd_s == ail_pkg::ACC_CONTROLLED) | (cmd_s == ail_pkg::ACC_PERMITTED);
  // Controlled may go back to no access without a fresh search
  wire raise_ok = (state == ail_pkg::ACC_CONTROLLED) ? ~trip : (~need_search & ~trip); // see R14 see R15
  wire cmd_ok = cmd_v & cmd_legal & (to_entry ? stoppers_in : raise_ok) & ~(kt & to_entry); // see R07 see R16
  // A pending entry request withdraws beam so the stoppers go in first
  wire entry_req = cmd_v & cmd_legal & to_entry & ((state == ail_pkg::ACC_NO) | (state == ail_pkg::ACC_RESTRICTED)); // see R07

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ail_pkg::ACC_PERMITTED; // see R22
    end else if (cmd_ok) begin
      state <= cmd_s;
    end
  end

  // ****************************************
  // Search sequence and key test
  // ****************************************
  wire both_reset = srl & src;

  always_ff @(posedge clk) begin
    if (srst) begin
      search <= ail_pkg::AIL_S_IDLE;
    end else begin
      case (search)
        ail_pkg::AIL_S_IDLE: if (sp & need_search) search <= ail_pkg::AIL_S_PRESET; // see R04
        ail_pkg::AIL_S_PRESET: search <= ail_pkg::AIL_S_PROGRESS;
        ail_pkg::AIL_S_PROGRESS: if (both_reset & e_a & e_b & emg) search <= ail_pkg::AIL_S_DONE; // see R04
        ail_pkg::AIL_S_DONE: search <= ail_pkg::AIL_S_IDLE;
        default: search <= ail_pkg::AIL_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      kt <= 1'b0;
    end else begin
      kt <= ktr & (state == ail_pkg::ACC_RESTRICTED) & stoppers_in; // see R16
    end
  end

  // ****************************************
  // Warning timer
  // ****************************************
  // Long count; the parameter lets simulation shorten it
  // Any drop out of a raised state or a trip clears the warning until the next start
  logic [37:0] wcnt;
  logic warn_run, warn_done;
  wire raised = (state == ail_pkg::ACC_NO) | (state == ail_pkg::ACC_RESTRICTED);
  always_ff @(posedge clk) begin
    if (srst | ~raised | trip) begin
      wcnt <= 38'h0;
      warn_run <= 1'b0;
      warn_done <= 1'b0;
    end else if (wst & ~warn_run & ~warn_done) begin
      warn_run <= 1'b1;
    end else if (warn_run) begin
      if (wcnt == 38'(WARN_CYC - 1)) begin
        warn_run <= 1'b0; // see R05
        warn_done <= 1'b1;
      end else begin
        wcnt <= wcnt + 38'h1;
      end
    end
  end

  // ****************************************
  // Permissives and outputs
  // ****************************************
  wire base_ok = chains_ok & ~trip & ~need_search & bok & warn_done; // see R04 see R08 see R10 see R19
  wire beam_ok = base_ok & (state == ail_pkg::ACC_NO) & stoppers_ok & ~kt & ~entry_req; // see R01 see R12 see R13
  // Output decoding, registered below
  wire next_key_release = krr & (state == ail_pkg::ACC_CONTROLLED | kt) & stoppers_in & ~(kt & team); // see R17
  wire next_latch_release = lrr & ~raised & stoppers_in; // see R06
  wire next_flash = warn_run & ~kt; // see R05
  wire next_dim = warn_done & ~kt;
  wire next_full = kt | ~raised; // see R17
  wire next_secure = ~need_search & ~trip & chains_ok & warn_done & keys; // see R18

  wire haz_ok = chains_ok & ~trip & ~need_search & raised; // see R13 see R15 see R06
  wire [N_STOP-1:0] next_perm = {N_STOP{beam_ok}}; // see R09
  always_ff @(posedge clk) begin
    if (srst) begin
      stop_perm_a <= '0;
      stop_perm_b <= '0;
      hazard_perm <= 1'b0;
      beam_perm <= 1'b0;
      key_release <= 1'b0;
      latch_release <= 1'b0;
      lights_flash <= 1'b0;
      lights_dim <= 1'b0;
      lights_full <= 1'b1;
      audio_warn <= 1'b0;
      secure <= 1'b0;
    end else begin
      stop_perm_a <= next_perm; // see R09
      stop_perm_b <= next_perm;
      hazard_perm <= haz_ok; // see R06
      beam_perm <= beam_ok;
      key_release <= next_key_release;
      latch_release <= next_latch_release;
      lights_flash <= next_flash;
      lights_dim <= next_dim;
      lights_full <= next_full;
      audio_warn <= warn_run;
      secure <= next_secure;
    end
  end

  assign access_state = state;
  assign search_step = search;
  assign trip_latched = trip;
  assign search_needed = need_search;
  assign key_test_active = kt;
endmodule

// [hdl/ail_pkg.sv]
// Constants for the access interlock logic
package ail_pkg;
  // Access state encodings
  localparam logic [1:0] ACC_NO = 2'h0;
  localparam logic [1:0] ACC_RESTRICTED = 2'h1;
  localparam logic [1:0] ACC_CONTROLLED = 2'h2;
  localparam logic [1:0] ACC_PERMITTED = 2'h3;
  // Timing
  localparam int CLK_HZ = 50000000;
  localparam int WARN_SECONDS = 120;
  localparam int RESP_MS = 100;
  localparam longint WARN_CYCLES = longint'(WARN_SECONDS) * longint'(CLK_HZ);
  localparam int RESP_CYCLES = RESP_MS * (CLK_HZ / 1000);
  // Search sequence states
  typedef enum logic [1:0] {AIL_S_IDLE, AIL_S_PRESET, AIL_S_PROGRESS, AIL_S_DONE} ail_search_t;
endpackage

// [tb/ail_checker.sv]
// Concurrent checks on the access interlock ports
`timescale 1ns/1ps
module ail_checker #(
  parameter int N_STOP = 3,
  parameter longint WARN_CYC = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic doors_closed_a,
  input wire logic eoff_ok_b,
  input wire logic burst_ok,
  input wire logic intlk_reset_btn,
  input wire logic [N_STOP-1:0] stop_in_a,
  input wire logic [N_STOP-1:0] stop_in_b,
  input wire logic [1:0] access_state,
  input wire logic [1:0] search_step,
  input wire logic search_needed,
  input wire logic [N_STOP-1:0] stop_perm_a,
  input wire logic [N_STOP-1:0] stop_perm_b,
  input wire logic hazard_perm,
  input wire logic beam_perm,
  input wire logic lights_flash,
  input wire logic trip_latched
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  longint flash_cnt;
  // Length of the current flash run, to bound the warning
  always_ff @(posedge clk) begin
    flash_cnt <= (srst || !lights_flash) ? 0 : flash_cnt + 1;
  end
  sequence perms_off;
    !beam_perm && !hazard_perm && stop_perm_a == 0 && stop_perm_b == 0;
  endsequence
  a_door_drops_all: assert property (!doors_closed_a |-> ##3 perms_off)
    else $error("door open did not drop permissives");
  a_chain_b_drops: assert property (!eoff_ok_b |-> ##3 perms_off)
    else $error("chain b trip did not drop permissives");
  a_burst_kills_beam: assert property (!burst_ok |-> ##3 !beam_perm)
    else $error("burst chamber did not kill beam");
  a_no_beam_entry: assert property (access_state != ail_pkg::ACC_NO |-> ##1 !beam_perm)
    else $error("beam allowed outside no access");
  a_no_hazard_entry: assert property (access_state[1] |-> ##1 !hazard_perm)
    else $error("hazard allowed in entry state");
  a_beam_after_search: assert property ($rose(beam_perm) |->
    !search_needed && !trip_latched && !lights_flash)
    else $error("beam raised before search and warning");
  a_search_done_clears: assert property (search_step == 2'h3 |-> ##1 !search_needed)
    else $error("search complete left search pending");
  a_trip_needs_reset: assert property ($fell(trip_latched) |->
    $past(intlk_reset_btn, 3) || $past(intlk_reset_btn, 4))
    else $error("trip cleared without operator reset");
  a_flash_bounded: assert property (flash_cnt <= WARN_CYC + 1)
    else $error("lights flashed too long");
  a_entry_stoppers: assert property ($changed(access_state) && access_state == ail_pkg::ACC_CONTROLLED |->
    &($past(stop_in_a, 3)) && &($past(stop_in_b, 3)))
    else $error("entry state without stoppers in");
endmodule
bind ail_access_interlock ail_checker #(.N_STOP(N_STOP), .WARN_CYC(WARN_CYC)) i_ail_checker (.*);

// [tb/ail_far_side.sv]
// Far-side model of the stoppers and their status contacts
`timescale 1ns/1ps
module ail_far_side #(
  parameter int N_STOP = 3
) (
  input wire logic clk,
  input wire logic [N_STOP-1:0] stop_perm_a,
  input wire logic [N_STOP-1:0] stop_perm_b,
  output logic [N_STOP-1:0] stop_in_a,
  output logic [N_STOP-1:0] stop_in_b,
  output logic [N_STOP-1:0] stop_ok
);
  initial begin
    stop_in_a = '1;
    stop_in_b = '1;
  end
  // Stopper leaves only with both permissives, one cycle of travel
  always @(posedge clk) begin
    stop_in_a <= ~(stop_perm_a & stop_perm_b);
    stop_in_b <= ~(stop_perm_a & stop_perm_b);
  end
  assign stop_ok = '1;
endmodule

// [tb/testbench.sv]
// Self-checking bench for the access interlock logic
`timescale 1ns/1ps
module testbench;
  localparam longint WC = 20;
  logic clk = 0, srst = 1, pre = 0, rl = 0, rc = 0, ir = 0, rv = 0, hw = 0, pv = 0, ws = 0;
  logic [5:0] viol = 0;
  logic [1:0] rs = 0, ps = 0, acc, step;
  logic [2:0] si_a, si_b, s_ok, sp_a, sp_b;
  logic hz, bm, fl, dim, full, trip, need;
  int n_errors = 0, compares = 0, cyc = 0;
  always #10 clk = ~clk;
  ail_access_interlock #(.WARN_CYC(WC)) i_ail_access_interlock (.clk(clk), .srst(srst),
    .doors_closed_a(!viol[0]), .doors_closed_b(!viol[1]), .eoff_ok_a(!viol[2]), .eoff_ok_b(!viol[3]),
    .burst_ok(!viol[4]), .emerg_entry_ok(!viol[5]), .keys_all_in(1'b1), .stop_in_a(si_a), .stop_in_b(si_b),
    .stop_ok(s_ok), .search_preset_btn(pre), .search_reset_local(rl), .search_reset_ctrl(rc),
    .intlk_reset_btn(ir), .remote_cmd_valid(rv), .remote_cmd_state(rs), .remote_hw_enable(hw),
    .panel_cmd_valid(pv), .panel_cmd_state(ps), .key_test_req(1'b0), .key_release_req(1'b0),
    .latch_release_req(1'b0), .team_entered(1'b0), .warn_start(ws), .access_state(acc), .search_step(step),
    .stop_perm_a(sp_a), .stop_perm_b(sp_b), .hazard_perm(hz), .beam_perm(bm), .key_release(),
    .latch_release(), .lights_flash(fl), .lights_dim(dim), .lights_full(full), .audio_warn(), .secure(),
    .trip_latched(trip), .search_needed(need), .key_test_active());
  ail_far_side i_ail_far_side (.clk(clk), .stop_perm_a(sp_a), .stop_perm_b(sp_b), .stop_in_a(si_a),
    .stop_in_b(si_b), .stop_ok(s_ok));
  task w(input int n); repeat (n) @(negedge clk); endtask
  task chk(input string nm, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task panel(input logic [1:0] s); ps = s; pv = 1; w(4); pv = 0; w(4); endtask
  // Warning must run its full length before beam
  task warn_and_check;
    ws = 1; w(4); ws = 0; w(4);
    chk("flashing", fl, 1'b1);
    chk("beam_in_warn", bm, 1'b0);
    w(WC + 10);
    chk("lights_dim", dim, 1'b1);
    chk("beam_on", bm, 1'b1);
    chk("hazard_on", hz, 1'b1);
    chk("stop_perm_on", &sp_a && &sp_b, 1'b1);
  endtask
  task arm;
    panel(ail_pkg::ACC_CONTROLLED);
    pre = 1; w(4); pre = 0; w(4);
    rl = 1; rc = 1; w(4); rl = 0; rc = 0; w(4);
    chk("search_done", need, 1'b0);
    ir = 1; w(4); ir = 0; w(4);
    chk("trip_clear", trip, 1'b0);
    panel(ail_pkg::ACC_NO);
    warn_and_check();
  endtask
  initial begin
    void'($urandom(32'h0dce));
    w(2);
    srst = 0;
    w(1);
    chk("rst_beam", bm || hz || |sp_a, 1'b0);
    chk("rst_trip", trip && need && full, 1'b1);
    chk("rst_state", acc == ail_pkg::ACC_PERMITTED, 1'b1);
    for (int i = 0; i < 6; i++) begin
      arm();
      if (i == 0) begin
        rs = ail_pkg::ACC_CONTROLLED; rv = 1; w(6);
        chk("remote_no_hw", acc == ail_pkg::ACC_NO, 1'b1);
        hw = 1; w(12); rv = 0; hw = 0; w(4);
        chk("remote_hw", acc == ail_pkg::ACC_CONTROLLED, 1'b1);
        chk("ctrl_beam", bm || hz, 1'b0);
        panel(ail_pkg::ACC_NO);
        warn_and_check();
      end
      // Momentary fault of one to three cycles must still latch
      viol = 6'h1 << $urandom_range(5, 0);
      w($urandom_range(3, 1));
      viol = 0;
      w(4);
      chk("viol_beam", bm, 1'b0);
      chk("viol_stop", |sp_a || |sp_b, 1'b0);
      chk("viol_trip", trip, 1'b1);
    end
    wrap_up();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
endmodule
